// File: core/scr_pkg.sv
// scr_pkg: constants, register map and types of the sleep clock and reset controller.
// assumes a single 25 MHz system clock and a 32-bit plain register port.
package scr_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned RESET_HOLD_MS = 30;
	localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned RESET_SHORT_CYC = 2;
	localparam int unsigned QUAL_CYC = 64;
	localparam int unsigned DS_WINDOW_CYC = 10;
	localparam logic [31:0] WDT_LOAD_RST = 32'h0000ffff;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_WDT_LOAD = 8'h08;
	localparam logic [7:0] ADDR_WDT_CMD = 8'h0c;
	localparam logic [7:0] ADDR_INT_STAT = 8'h10;
	localparam logic [7:0] ADDR_INT_MASK = 8'h14;

	// ctrl fields
	localparam int unsigned CTRL_RUN_SEL = 0;
	localparam int unsigned CTRL_DS_SEL = 2;
	localparam int unsigned CTRL_PLL_SRC_PREC = 4;
	localparam int unsigned CTRL_PREC_OFF_DS = 5;
	localparam int unsigned CTRL_SINGLE_ENDED = 6;
	localparam int unsigned CTRL_FAST_CLK = 7;
	localparam int unsigned CTRL_W = 8;
	localparam logic [7:0] CTRL_RST = 8'h04;

	// wdt command fields
	localparam int unsigned WDT_EN = 0;
	localparam int unsigned WDT_RESET_EN = 1;
	localparam int unsigned WDT_FEED = 2;

	// interrupt event bits
	localparam int unsigned EV_QUAL_FAIL = 0;
	localparam int unsigned EV_WDT_TIMEOUT = 1;
	localparam int unsigned EV_PREFETCH = 2;
	localparam int unsigned EV_DS_CFG_LOST = 3;
	localparam int unsigned EV_WAKE = 4;
	localparam int unsigned EV_W = 5;

	typedef enum logic [1:0] {
		SCR_SRC_MAIN = 2'b00,
		SCR_SRC_PREC = 2'b01,
		SCR_SRC_LOWF = 2'b10,
		SCR_SRC_PLL = 2'b11
	} scr_src_e;

	typedef enum logic [1:0] {
		SCR_ST_RUN = 2'b00,
		SCR_ST_SLEEP = 2'b01,
		SCR_ST_DSLEEP = 2'b10,
		SCR_ST_DEAD = 2'b11
	} scr_state_e;

endpackage

// File: core/scr_ctrl.sv
// scr_ctrl: run, sleep and deep-sleep clock source control with reset handling.
// assumes cpu sleep requests are single-cycle pulses on clk_in; the reset and
// oscillator-status pins are asynchronous and are synchronised here.
//
// Contract
// - main oscillator check flags errors only during power-up qualification
// - second watchdog runs from precision oscillator, independent of main oscillator
// - wake from sleep at >=40 MHz with irqs off may fetch stale prefetch data
// - system reset in deep sleep, main both modes, precision off: main disabled
// - that unclocked state is left only by power-on reset
// - watchdog reset within 10 cycles of deep-sleep entry loses deep-sleep settings
// - after one run-clocked deep sleep, programmed deep-sleep settings apply again
// - main oscillator amplifier stays on even with a single-ended clock
`timescale 1ns/100ps

module scr_ctrl #(
	parameter int unsigned RESET_HOLD_CYC = scr_pkg::RESET_HOLD_CYC,
	parameter int unsigned QUAL_CYC = scr_pkg::QUAL_CYC
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rd_data_out,
	input wire logic sleep_req_in,
	input wire logic deep_sleep_req_in,
	input wire logic wake_in,
	input wire logic irq_disabled_in,
	input wire logic safe_wfi_in,
	input wire logic sw_reset_req_in,
	input wire logic ext_reset_n_in,
	input wire logic main_osc_ok_in,
	output logic [1:0] sys_clk_sel_out,
	output logic [1:0] power_state_out,
	output logic main_osc_en_out,
	output logic main_osc_amp_en_out,
	output logic precision_osc_en_out,
	output logic pll_en_out,
	output logic sys_reset_out,
	output logic clock_dead_out,
	output logic prefetch_invalid_out,
	output logic irq_out
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] rst_pin_sync;
	logic [2:0] osc_pin_sync;
	logic ext_rst_level;
	logic osc_ok_level;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rst_pin_sync <= 3'h0;
			osc_pin_sync <= 3'h0;
		end else begin
			rst_pin_sync <= {rst_pin_sync[1:0], ~ext_reset_n_in};
			osc_pin_sync <= {osc_pin_sync[1:0], main_osc_ok_in};
		end
	end

	// a change only counts once stages two and three agree
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ext_rst_level <= 1'b0;
			osc_ok_level <= 1'b0;
		end else begin
			if (rst_pin_sync[1] == rst_pin_sync[2]) begin
				ext_rst_level <= rst_pin_sync[2];
			end
			if (osc_pin_sync[1] == osc_pin_sync[2]) begin
				osc_ok_level <= osc_pin_sync[2];
			end
		end
	end

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	logic [scr_pkg::CTRL_W-1:0] ctrl;
	logic [31:0] wdt_load;
	logic [31:0] wdt_count;
	logic wdt_en;
	logic wdt_reset_en;
	logic [scr_pkg::EV_W-1:0] int_stat;
	logic [scr_pkg::EV_W-1:0] int_mask;
	scr_pkg::scr_state_e state;
	scr_pkg::scr_state_e next_state;
	logic [1:0] active_sel;
	logic ds_cfg_lost;
	logic [3:0] ds_age;
	logic [$clog2(QUAL_CYC+1)-1:0] qual_count;
	logic qual_done;
	logic [$clog2(RESET_HOLD_CYC+2)-1:0] ext_hold;

	wire [1:0] run_sel = ctrl[scr_pkg::CTRL_RUN_SEL +: 2];
	wire [1:0] ds_sel = ctrl[scr_pkg::CTRL_DS_SEL +: 2];
	wire pll_src_prec = ctrl[scr_pkg::CTRL_PLL_SRC_PREC];
	wire prec_off_ds = ctrl[scr_pkg::CTRL_PREC_OFF_DS];

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	wire sel_ctrl = (addr_in == scr_pkg::ADDR_CTRL);
	wire sel_status = (addr_in == scr_pkg::ADDR_STATUS);
	wire sel_load = (addr_in == scr_pkg::ADDR_WDT_LOAD);
	wire sel_cmd = (addr_in == scr_pkg::ADDR_WDT_CMD);
	wire sel_istat = (addr_in == scr_pkg::ADDR_INT_STAT);
	wire sel_imask = (addr_in == scr_pkg::ADDR_INT_MASK);
	wire wdt_feed = wr_in && sel_cmd && wr_data_in[scr_pkg::WDT_FEED];

	wire [31:0] status_word = {23'h0, qual_done, ds_cfg_lost, clock_dead_out,
		active_sel, state, osc_ok_level, wdt_en};
	logic [31:0] rd_mux;
	always_comb begin
		if (sel_ctrl) begin
			rd_mux = {24'h0, ctrl};
		end else if (sel_status) begin
			rd_mux = status_word;
		end else if (sel_load) begin
			rd_mux = wdt_load;
		end else if (sel_cmd) begin
			rd_mux = {30'h0, wdt_reset_en, wdt_en};
		end else if (sel_istat) begin
			rd_mux = {27'h0, int_stat};
		end else if (sel_imask) begin
			rd_mux = {27'h0, int_mask};
		end else begin
			rd_mux = 32'h0;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_data_out <= 32'h0;
		end else begin
			rd_data_out <= rd_in ? rd_mux : 32'h0;
		end
	end

	// ----------------------------------------
	// watchdog on the precision oscillator
	// ----------------------------------------
	// counting is gated only by wdt_en and the precision oscillator, so a dead main
	// oscillator cannot stop the recovery reset
	wire wdt_tick = wdt_en && precision_osc_en_out;
	wire wdt_expire = wdt_tick && (wdt_count == 32'h0);
	wire wdt_reset = wdt_expire && wdt_reset_en;

	// ----------------------------------------
	// external reset qualification
	// ----------------------------------------
	// a low-freq deep sleep needs the long hold before the pin is honoured
	wire lowf_ds = (state == scr_pkg::SCR_ST_DSLEEP) && (active_sel == scr_pkg::SCR_SRC_LOWF);
	wire [$clog2(RESET_HOLD_CYC+2)-1:0] hold_need = lowf_ds ?
		($clog2(RESET_HOLD_CYC+2))'(RESET_HOLD_CYC) :
		($clog2(RESET_HOLD_CYC+2))'(scr_pkg::RESET_SHORT_CYC);
	wire ext_reset = ext_rst_level && (ext_hold == hold_need);
	wire any_sys_reset = ext_reset || wdt_reset || sw_reset_req_in;

	// dead trap: main oscillator dropped with no clock left to run on
	wire trap = any_sys_reset && (state == scr_pkg::SCR_ST_DSLEEP) &&
		(run_sel == scr_pkg::SCR_SRC_MAIN) && (ds_sel == scr_pkg::SCR_SRC_MAIN) &&
		prec_off_ds;
	wire live_reset = any_sys_reset && (state != scr_pkg::SCR_ST_DEAD);
	wire ds_enter = deep_sleep_req_in && (state == scr_pkg::SCR_ST_RUN);
	wire sleep_enter = sleep_req_in && !deep_sleep_req_in && (state == scr_pkg::SCR_ST_RUN);
	wire sleep_wake = wake_in && (state == scr_pkg::SCR_ST_SLEEP);
	wire ds_wake = wake_in && (state == scr_pkg::SCR_ST_DSLEEP);
	wire lose_cfg = wdt_reset && (state == scr_pkg::SCR_ST_DSLEEP) &&
		(ds_age < 4'(scr_pkg::DS_WINDOW_CYC));
	// stale prefetch only without the safe wfi plus dummy instruction sequence
	wire prefetch_bad = sleep_wake && ctrl[scr_pkg::CTRL_FAST_CLK] && irq_disabled_in &&
		!safe_wfi_in;
	wire qual_fail = !qual_done && (qual_count == QUAL_CYC[$bits(qual_count)-1:0]) &&
		!osc_ok_level;

	always_comb begin
		next_state = state;
		case (state)
			scr_pkg::SCR_ST_RUN: begin
				if (ds_enter) begin
					next_state = scr_pkg::SCR_ST_DSLEEP;
				end else if (sleep_enter) begin
					next_state = scr_pkg::SCR_ST_SLEEP;
				end
			end
			scr_pkg::SCR_ST_SLEEP: begin
				if (live_reset || wake_in) begin
					next_state = scr_pkg::SCR_ST_RUN;
				end
			end
			scr_pkg::SCR_ST_DSLEEP: begin
				if (trap) begin
					next_state = scr_pkg::SCR_ST_DEAD;
				end else if (live_reset || wake_in) begin
					next_state = scr_pkg::SCR_ST_RUN;
				end
			end
			default: begin
				next_state = scr_pkg::SCR_ST_DEAD;
			end
		endcase
	end

	// ----------------------------------------
	// power state and clock selection
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state <= scr_pkg::SCR_ST_RUN;
			active_sel <= 2'h0;
			ds_cfg_lost <= 1'b0;
			ds_age <= 4'h0;
		end else begin
			state <= next_state;
			if (ds_enter) begin
				// one run-clocked deep sleep after a lost setting, then normal again
				active_sel <= ds_cfg_lost ? run_sel : ds_sel;
			end else if (next_state == scr_pkg::SCR_ST_DEAD) begin
				active_sel <= active_sel;
			end else if (next_state != scr_pkg::SCR_ST_DSLEEP) begin
				active_sel <= run_sel;
			end
			if (lose_cfg) begin
				ds_cfg_lost <= 1'b1;
			end else if (ds_enter) begin
				ds_cfg_lost <= 1'b0;
			end
			if (ds_enter) begin
				ds_age <= 4'h0;
			end else if (ds_age != 4'hf) begin
				ds_age <= ds_age + 4'h1;
			end
		end
	end

	// ----------------------------------------
	// software registers and watchdog
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl <= scr_pkg::CTRL_RST;
			wdt_load <= scr_pkg::WDT_LOAD_RST;
			wdt_en <= 1'b0;
			wdt_reset_en <= 1'b0;
			int_mask <= 5'h0;
		end else begin
			if (wr_in && sel_ctrl) begin
				ctrl <= wr_data_in[scr_pkg::CTRL_W-1:0];
			end
			if (wr_in && sel_load) begin
				wdt_load <= wr_data_in;
			end
			if (wr_in && sel_cmd) begin
				wdt_en <= wr_data_in[scr_pkg::WDT_EN];
				wdt_reset_en <= wr_data_in[scr_pkg::WDT_RESET_EN];
			end
			if (wr_in && sel_imask) begin
				int_mask <= wr_data_in[scr_pkg::EV_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wdt_count <= scr_pkg::WDT_LOAD_RST;
		end else if (wdt_feed || wdt_expire || (wr_in && sel_load)) begin
			wdt_count <= (wr_in && sel_load) ? wr_data_in : wdt_load;
		end else if (wdt_tick) begin
			wdt_count <= wdt_count - 32'h1;
		end
	end

	// ----------------------------------------
	// qualification and reset hold counters
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			qual_count <= '0;
			qual_done <= 1'b0;
			ext_hold <= '0;
		end else begin
			// checking stops for good after the window, a later stall goes unseen
			if (!qual_done) begin
				if (qual_count == QUAL_CYC[$bits(qual_count)-1:0]) begin
					qual_done <= 1'b1;
				end else begin
					qual_count <= qual_count + 1'b1;
				end
			end
			if (!ext_rst_level) begin
				ext_hold <= '0;
			end else if (ext_hold <= hold_need) begin
				ext_hold <= ext_hold + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// interrupt status, set wins over clear
	// ----------------------------------------
	wire [scr_pkg::EV_W-1:0] ev_set = {ds_wake | sleep_wake, lose_cfg, prefetch_bad,
		wdt_expire, qual_fail};
	wire [scr_pkg::EV_W-1:0] ev_clr = (wr_in && sel_istat) ?
		wr_data_in[scr_pkg::EV_W-1:0] : 5'h0;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			int_stat <= 5'h0;
			prefetch_invalid_out <= 1'b0;
			sys_reset_out <= 1'b0;
		end else begin
			int_stat <= (int_stat & ~ev_clr) | ev_set;
			prefetch_invalid_out <= prefetch_bad;
			sys_reset_out <= live_reset;
		end
	end

	// ----------------------------------------
	// oscillator and clock outputs
	// ----------------------------------------
	wire in_dead = (state == scr_pkg::SCR_ST_DEAD);
	wire in_ds = (state == scr_pkg::SCR_ST_DSLEEP);
	wire uses_pll = (active_sel == scr_pkg::SCR_SRC_PLL);

	assign sys_clk_sel_out = active_sel;
	assign power_state_out = state;
	assign clock_dead_out = in_dead;
	assign main_osc_en_out = !in_dead && ((active_sel == scr_pkg::SCR_SRC_MAIN) ||
		(uses_pll && !pll_src_prec));
	// the amplifier ignores single-ended mode; costs power, not function
	assign main_osc_amp_en_out = main_osc_en_out;
	assign precision_osc_en_out = !(in_dead || (in_ds && prec_off_ds));
	assign pll_en_out = uses_pll && !in_dead;
	assign irq_out = |(int_stat & int_mask);

endmodule

// File: dv/scr_ctrl_props.sv
// scr_ctrl_props: port-level checks of the sleep clock and reset controller.
// assumes it is bound to scr_ctrl and sees only that module's ports.
`timescale 1ns/100ps

module scr_ctrl_props (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic rd_in,
	input wire logic [31:0] rd_data_out,
	input wire logic deep_sleep_req_in,
	input wire logic wake_in,
	input wire logic irq_disabled_in,
	input wire logic safe_wfi_in,
	input wire logic sw_reset_req_in,
	input wire logic sys_reset_out,
	input wire logic [1:0] sys_clk_sel_out,
	input wire logic [1:0] power_state_out,
	input wire logic main_osc_en_out,
	input wire logic main_osc_amp_en_out,
	input wire logic precision_osc_en_out,
	input wire logic pll_en_out,
	input wire logic clock_dead_out,
	input wire logic prefetch_invalid_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// ----------------
	// assertions
	// ----------------
	AST_AMP_ON: assert property (main_osc_amp_en_out == main_osc_en_out)
		else $error("amplifier enable differs from oscillator enable");
	// dead state must also swallow any further reset pulse
	AST_DEAD_HOLD: assert property (clock_dead_out |=> clock_dead_out && !sys_reset_out)
		else $error("dead state left or reset taken without power-on");
	AST_DEAD_CAUSE: assert property ($rose(clock_dead_out) |-> $past(power_state_out) == 2'h2)
		else $error("dead state entered from outside deep sleep");
	AST_DEAD_OFF: assert property (clock_dead_out |-> power_state_out == 2'h3 &&
		!main_osc_en_out && !precision_osc_en_out && !pll_en_out)
		else $error("clock still enabled in dead state");
	AST_PLL_SEL: assert property (!clock_dead_out |-> pll_en_out == (sys_clk_sel_out == 2'h3))
		else $error("pll enable does not follow the active source");
	AST_DS_ENTRY: assert property (power_state_out == 2'h0 && deep_sleep_req_in &&
		!sw_reset_req_in |=> power_state_out == 2'h2)
		else $error("deep sleep request not taken");
	AST_DS_WAKE: assert property (power_state_out == 2'h2 && wake_in &&
		!sw_reset_req_in |=> power_state_out == 2'h0)
		else $error("wake from deep sleep not taken");
	AST_PREFETCH: assert property (prefetch_invalid_out |-> $past(irq_disabled_in) &&
		!$past(safe_wfi_in) ##1 !prefetch_invalid_out)
		else $error("prefetch hazard pulse without its cause");
	AST_RD_IDLE: assert property (!rd_in |=> rd_data_out == 32'h0)
		else $error("read data outside the read answer cycle");
	COV_DS: cover property (power_state_out == 2'h2);
	COV_DEAD: cover property ($rose(clock_dead_out));
	COV_PF: cover property (prefetch_invalid_out);
endmodule

bind scr_ctrl scr_ctrl_props i_props (.clk_in, .reset_in, .rd_in, .rd_data_out,
	.deep_sleep_req_in, .wake_in, .irq_disabled_in, .safe_wfi_in, .sw_reset_req_in,
	.sys_clk_sel_out, .power_state_out, .main_osc_en_out, .main_osc_amp_en_out,
	.precision_osc_en_out, .pll_en_out, .clock_dead_out, .prefetch_invalid_out,
	.sys_reset_out);

// File: dv/scr_ctrl_bench.sv
// scr_ctrl_bench: self-checking bench for scr_ctrl.
// assumes scr_pkg, scr_ctrl and the bound checker are compiled first.
`timescale 1ns/100ps

module scr_ctrl_bench;
	typedef struct {logic [7:0] a; logic [31:0] d;} scr_row_s;
	logic clk_in = 0, reset_in = 1, wr_in = 0, rd_in = 0, sleep_req_in = 0;
	logic deep_sleep_req_in = 0, wake_in = 0, irq_disabled_in = 0, safe_wfi_in = 0;
	logic sw_reset_req_in = 0, ext_reset_n_in = 1, main_osc_ok_in = 1;
	logic [7:0] addr_in = 0;
	logic [31:0] wr_data_in = 0, rd_data_out, v;
	logic [1:0] sys_clk_sel_out, power_state_out;
	logic main_osc_en_out, main_osc_amp_en_out, precision_osc_en_out, pll_en_out;
	logic sys_reset_out, clock_dead_out, prefetch_invalid_out, irq_out;
	int error_cnt = 0, n_tests = 0, cyc = 0, pf_cnt = 0, rst_cnt = 0, k, c;
	scr_row_s rows [7] = '{'{scr_pkg::ADDR_CTRL, 32'h4}, '{scr_pkg::ADDR_STATUS, 32'h102},
		'{scr_pkg::ADDR_WDT_LOAD, 32'hffff}, '{scr_pkg::ADDR_WDT_CMD, 32'h0},
		'{scr_pkg::ADDR_INT_STAT, 32'h0}, '{scr_pkg::ADDR_INT_MASK, 32'h0}, '{8'h18, 32'h0}};

	// short hold so the long-pulse case fits in the run
	scr_ctrl #(.RESET_HOLD_CYC(20), .QUAL_CYC(8)) i_dut (.clk_in, .reset_in, .addr_in,
		.wr_data_in, .wr_in, .rd_in, .rd_data_out, .sleep_req_in, .deep_sleep_req_in,
		.wake_in, .irq_disabled_in, .safe_wfi_in, .sw_reset_req_in, .ext_reset_n_in,
		.main_osc_ok_in, .sys_clk_sel_out, .power_state_out, .main_osc_en_out,
		.main_osc_amp_en_out, .precision_osc_en_out, .pll_en_out, .sys_reset_out,
		.clock_dead_out, .prefetch_invalid_out, .irq_out);

	always #20 clk_in = ~clk_in;

	// pulses counted away from the active edge to avoid a race
	always @(negedge clk_in) begin
		pf_cnt += prefetch_invalid_out;
		rst_cnt += sys_reset_out;
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// ----------------
	// tasks
	// ----------------
	task print_verdict();
		$display("checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 v = rd_data_out;
	endtask

	// m holds wake, software reset, deep sleep and sleep requests
	task pulse(input logic [3:0] m);
		@(posedge clk_in);
		{wake_in, sw_reset_req_in, deep_sleep_req_in, sleep_req_in} <= m;
		@(posedge clk_in);
		{wake_in, sw_reset_req_in, deep_sleep_req_in, sleep_req_in} <= 4'h0;
		#1;
	endtask

	task ext(input int n);
		@(posedge clk_in);
		ext_reset_n_in <= 1'b0;
		repeat (n) @(posedge clk_in);
		ext_reset_n_in <= 1'b1;
		repeat (8) @(posedge clk_in);
		#1;
	endtask

	// ----------------
	// sequence
	// ----------------
	initial begin
		repeat (16) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (12) @(posedge clk_in);
		foreach (rows[i]) begin
			rd(rows[i].a);
			chk(v, rows[i].d);
		end
		main_osc_ok_in <= 1'b0;
		wr(scr_pkg::ADDR_INT_MASK, 32'h10);
		// pll on main oscillator in run, so deep sleep runs on the precision oscillator
		wr(scr_pkg::ADDR_CTRL, 32'h47);
		@(posedge clk_in);
		#1 chk(sys_clk_sel_out, 32'h3);
		chk(main_osc_amp_en_out, 32'h1);
		pulse(4'h2);
		chk(sys_clk_sel_out, 32'h1);
		chk(irq_out, 32'h0);
		pulse(4'h8);
		chk(sys_clk_sel_out, 32'h3);
		rd(scr_pkg::ADDR_INT_STAT);
		chk(v, 32'h10);
		chk(irq_out, 32'h1);
		wr(scr_pkg::ADDR_INT_STAT, 32'h10);
		#1 chk(irq_out, 32'h0);
		irq_disabled_in <= 1'b1;
		wr(scr_pkg::ADDR_CTRL, 32'hcb);
		pulse(4'h1);
		chk(power_state_out, 32'h1);
		pulse(4'h8);
		repeat (2) @(posedge clk_in);
		chk(pf_cnt, 32'h1);
		safe_wfi_in <= 1'b1;
		pulse(4'h1);
		pulse(4'h8);
		repeat (2) @(posedge clk_in);
		chk(pf_cnt, 32'h1);
		// pll fed from the precision oscillator before a low-freq deep sleep
		wr(scr_pkg::ADDR_CTRL, 32'h1b);
		wr(scr_pkg::ADDR_WDT_LOAD, 32'h6);
		wr(scr_pkg::ADDR_WDT_CMD, 32'h3);
		pulse(4'h2);
		k = 0;
		while (rst_cnt == 0 && k < 20) begin
			@(posedge clk_in);
			k++;
		end
		wr(scr_pkg::ADDR_WDT_CMD, 32'h0);
		chk(rst_cnt, 32'h1);
		chk(power_state_out, 32'h0);
		rd(scr_pkg::ADDR_STATUS);
		chk(v[7], 32'h1);
		rd(scr_pkg::ADDR_INT_STAT);
		chk(v & 32'hb, 32'ha);
		pulse(4'h2);
		chk(sys_clk_sel_out, 32'h3);
		pulse(4'h8);
		pulse(4'h2);
		chk(sys_clk_sel_out, 32'h2);
		c = rst_cnt;
		ext(10);
		chk(power_state_out, 32'h2);
		ext(30);
		chk(rst_cnt, c + 1);
		chk(power_state_out, 32'h0);
		wr(scr_pkg::ADDR_CTRL, 32'h20);
		pulse(4'h2);
		pulse(4'h4);
		repeat (2) @(posedge clk_in);
		chk({clock_dead_out, main_osc_en_out, precision_osc_en_out}, 32'h4);
		c = rst_cnt;
		pulse(4'h4);
		ext(4);
		chk(rst_cnt, c);
		chk(clock_dead_out, 32'h1);
		reset_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
		#1 chk(clock_dead_out, 32'h0);
		repeat (20) @(posedge clk_in);
		rd(scr_pkg::ADDR_INT_STAT);
		chk(v, 32'h1);
		print_verdict();
	end
endmodule
